// ===== btc_core.sv
// Purpose: 16-bit timer counter core with double-buffered period and compares
// Assumes: one clock; event input comes from another domain and is synchronised
// Notes:   pwm waveforms are not generated; those modes select update point and set override with wave held low
// Summary of operation
// R1 - zero is bottom, all ones is max, active period value is top
// R2 - update condition loads valid buffers unless update lock set
// R3 - enable bit starts counting prescaled clock ticks
// R4 - event enable makes events the count tick instead of clock
// R5 - counter steps once per tick in chosen direction
// R6 - counting up, top returns to zero on next tick
// R7 - counting down, bottom reloads the active period
// R8 - software counter write wins over count, clear, reload
// R9 - direction may change while running
// R10 - period and compares each have buffer and valid flag in control f
// R11 - valid flag set on buffer write, cleared on update transfer
// R12 - compare and buffer both directly writable
// R13 - unbuffered period write changes top at once
// R14 - counter and period compared continuously; lower top means wrap first
// R15 - period buffer writable anytime, active period changes at update
// R16 - compare match sets channel flag on the next timer tick
// R17 - valid compare buffer copied at update, used from next count
// R18 - waveform drives pin only in waveform mode with channel enabled
// R19 - software must make the pin an output and may invert it
// R20 - frequency mode uses compare zero as top
// R21 - frequency mode toggles channel waveform on each match
// R22 - compare zero of zero without prescale toggles every clock
// R23 - compare flag stays until software writes one to it
`timescale 1ns/1ns
module btc_core
   import btc_pkg::*;
#(
   parameter int unsigned PRESCALE_W = 10
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // register port
   input  wire btc_req_type       bus_req,
   output logic [15:0]            rd_data,
   // event input from another domain
   input  wire logic              event_a,
   // pin override
   output logic [NCH-1:0]         wave_out,
   output logic [NCH-1:0]         wave_override
);
   logic [2:0]          clock_prescale_select_q;
   logic                enable_q;
   btc_waveform_mode_select_type      waveform_mode_select_q;
   logic [NCH-1:0]      ch_en_q;
   logic                dir_down_q;
   logic                lock_q;
   logic                eva_en_q;
   logic [CNT_W-1:0]    count_q;
   logic [CNT_W-1:0]    period_q;
   logic [CNT_W-1:0]    per_buf_q;
   logic                per_bv_q;
   logic [CNT_W-1:0]    cmp_q  [NCH];
   logic [CNT_W-1:0]    cbuf_q [NCH];
   logic [NCH-1:0]      cmp_bv_q;
   logic [NCH-1:0]      cmp_flag_q;
   logic [NCH-1:0]      match_q;
   logic [NCH-1:0]      wave_q;
   logic [PRESCALE_W-1:0] pre_q;
   logic                ev_s1_q;
   logic                ev_s2_q;
   logic                ev_s3_q;
   logic [15:0]         rd_data_q;
   logic [NCH-1:0]      wave_ovr_q;

   logic                tick;
   logic                pre_tick;
   logic [CNT_W-1:0]    top;
   logic                at_top;
   logic                at_bottom;
   logic                update;
   logic                do_load;

   function automatic logic sel(input logic [4:0] a, input logic [4:0] ofs);
      return bus_req.wr && (a == ofs);
   endfunction : sel

   // prescaler: division 1,2,4,8,16,64,256,1024 as usual for such timers
   always_comb begin
      case (clock_prescale_select_q)
         3'h0:    pre_tick = 1'b1;
         3'h1:    pre_tick = pre_q[0:0] == 1'h1;
         3'h2:    pre_tick = pre_q[1:0] == 2'h3;
         3'h3:    pre_tick = pre_q[2:0] == 3'h7;
         3'h4:    pre_tick = pre_q[3:0] == 4'hF;
         3'h5:    pre_tick = pre_q[5:0] == 6'h3F;
         3'h6:    pre_tick = pre_q[7:0] == 8'hFF;
         default: pre_tick = pre_q == '1;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n || !enable_q) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // event synchroniser; the second and third stages feed the edge detector
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ev_s1_q <= 1'b0;
         ev_s2_q <= 1'b0;
         ev_s3_q <= 1'b0;
      end else begin
         ev_s1_q <= event_a;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end

   assign tick = enable_q && (eva_en_q ? (ev_s2_q && !ev_s3_q) : pre_tick); // R3 R4

   assign top       = (waveform_mode_select_q == BTC_WG_FRQ) ? cmp_q[0] : period_q; // R20 R1
   assign at_top    = (count_q == top); // R14
   assign at_bottom = (count_q == CNT_BOTTOM); // R1

   // update at top when counting up, bottom when counting down; dual-slope modes use top, bottom or both
   always_comb begin
      case (waveform_mode_select_q)
         BTC_WG_DUAL_T:  update = at_top;
         BTC_WG_DUAL_B:  update = at_bottom;
         BTC_WG_DUAL_TB: update = at_top || at_bottom;
         default:        update = dir_down_q ? at_bottom : at_top;
      endcase
   end
   assign do_load = tick && update && !lock_q; // R2

   // control registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         enable_q   <= 1'b0;
         clock_prescale_select_q   <= 3'h0;
         waveform_mode_select_q   <= BTC_WG_NORMAL;
         ch_en_q    <= '0;
         dir_down_q <= 1'b0;
         lock_q     <= 1'b0;
         eva_en_q   <= 1'b0;
      end else begin
         if (sel(bus_req.addr, OFS_CTRL_A)) begin
            enable_q <= bus_req.wdata[BIT_ENABLE]; // R3
            clock_prescale_select_q <= bus_req.wdata[POS_CLOCK_PRESCALE_SELECT +: 3];
         end
         if (sel(bus_req.addr, OFS_CTRL_B)) begin
            waveform_mode_select_q <= btc_waveform_mode_select_type'(bus_req.wdata[2:0]);
            ch_en_q  <= bus_req.wdata[POS_CH_EN +: NCH];
         end
         if (sel(bus_req.addr, OFS_CTRL_E)) begin
            dir_down_q <= bus_req.wdata[BIT_DIR_DOWN]; // R9
            lock_q     <= bus_req.wdata[BIT_LOCK];
         end
         if (sel(bus_req.addr, OFS_EV_CTRL)) begin
            eva_en_q <= bus_req.wdata[BIT_EVA_EN]; // R4
         end
      end
   end

   // counter
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         count_q <= RST_ZERO;
      end else if (sel(bus_req.addr, OFS_COUNT)) begin
         count_q <= bus_req.wdata; // R8
      end else if (tick) begin
         if (dir_down_q) begin
            count_q <= at_bottom ? top : count_q - 1'b1; // R5 R7
         end else begin
            count_q <= at_top ? CNT_BOTTOM : count_q + 1'b1; // R5 R6 R14
         end
      end
   end

   // period and its buffer
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         period_q  <= RST_PERIOD;
         per_buf_q <= RST_PERIOD;
         per_bv_q  <= 1'b0;
      end else begin
         if (sel(bus_req.addr, OFS_PERIOD)) begin
            period_q <= bus_req.wdata; // R13
         end else if (do_load && per_bv_q) begin
            period_q <= per_buf_q; // R15 R2
         end
         if (sel(bus_req.addr, OFS_PER_BUF)) begin
            per_buf_q <= bus_req.wdata;
         end
         // a buffer write in the update cycle keeps the flag set
         if (sel(bus_req.addr, OFS_PER_BUF)) begin
            per_bv_q <= 1'b1; // R11
         end else if (do_load) begin
            per_bv_q <= 1'b0; // R11
         end else if (sel(bus_req.addr, OFS_CTRL_F)) begin
            per_bv_q <= bus_req.wdata[BIT_PER_BV]; // R10
         end
      end
   end

   // compare channels
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      always_ff @(posedge clock) begin
         if (!reset_n) begin
            cmp_q[i]    <= RST_ZERO;
            cbuf_q[i]   <= RST_ZERO;
            cmp_bv_q[i] <= 1'b0;
         end else begin
            if (sel(bus_req.addr, OFS_CMP_BASE + 5'(i))) begin
               cmp_q[i] <= bus_req.wdata; // R12
            end else if (do_load && cmp_bv_q[i]) begin
               cmp_q[i] <= cbuf_q[i]; // R17
            end
            if (sel(bus_req.addr, OFS_CBUF_BASE + 5'(i))) begin
               cbuf_q[i]   <= bus_req.wdata; // R12
               cmp_bv_q[i] <= 1'b1; // R11
            end else if (do_load) begin
               cmp_bv_q[i] <= 1'b0; // R11
            end else if (sel(bus_req.addr, OFS_CTRL_F)) begin
               cmp_bv_q[i] <= bus_req.wdata[POS_CMP_BV + i]; // R10
            end
         end
      end

      // match is registered on a tick, acted on at the following tick
      always_ff @(posedge clock) begin
         if (!reset_n) begin
            match_q[i] <= 1'b0;
         end else if (tick) begin
            match_q[i] <= (count_q == cmp_q[i]); // R16
         end
      end

      // set wins over a simultaneous clear-by-one
      always_ff @(posedge clock) begin
         if (!reset_n) begin
            cmp_flag_q[i] <= 1'b0;
         end else if (tick && match_q[i]) begin
            cmp_flag_q[i] <= 1'b1; // R16
         end else if (sel(bus_req.addr, OFS_FLAGS) && bus_req.wdata[i]) begin
            cmp_flag_q[i] <= 1'b0; // R23
         end
      end

      always_ff @(posedge clock) begin
         if (!reset_n || waveform_mode_select_q != BTC_WG_FRQ) begin
            wave_q[i] <= 1'b0;
         end else if (tick && match_q[i]) begin
            wave_q[i] <= !wave_q[i]; // R21 R22
         end
      end

      always_ff @(posedge clock) begin
         if (!reset_n) begin
            wave_ovr_q[i] <= 1'b0;
         end else begin
            wave_ovr_q[i] <= (waveform_mode_select_q != BTC_WG_NORMAL) && ch_en_q[i]; // R18
         end
      end
   end

   // read port: data in the cycle after the read strobe
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rd_data_q <= RST_ZERO;
      end else if (bus_req.rd) begin
         rd_data_q <= RST_ZERO;
         case (bus_req.addr)
            OFS_CTRL_A:  rd_data_q <= 16'({clock_prescale_select_q, enable_q});
            OFS_CTRL_B:  rd_data_q <= 16'({ch_en_q, 1'b0, waveform_mode_select_q});
            OFS_CTRL_E:  rd_data_q <= 16'({lock_q, dir_down_q});
            OFS_CTRL_F:  rd_data_q <= 16'({cmp_bv_q, per_bv_q}); // R10
            OFS_EV_CTRL: rd_data_q <= 16'(eva_en_q);
            OFS_FLAGS:   rd_data_q <= 16'(cmp_flag_q);
            OFS_COUNT:   rd_data_q <= count_q;
            OFS_PERIOD:  rd_data_q <= period_q;
            OFS_PER_BUF: rd_data_q <= per_buf_q;
            5'h09:       rd_data_q <= cmp_q[0];
            5'h0A:       rd_data_q <= cmp_q[1];
            5'h0B:       rd_data_q <= cmp_q[2];
            5'h0C:       rd_data_q <= cbuf_q[0];
            5'h0D:       rd_data_q <= cbuf_q[1];
            5'h0E:       rd_data_q <= cbuf_q[2];
            default:     rd_data_q <= RST_ZERO;
         endcase
      end
   end

   // pin direction and inversion stay in the port logic outside this block (R19)
   assign rd_data       = rd_data_q;
   assign wave_out      = wave_q;
   assign wave_override = wave_ovr_q;
endmodule : btc_core

// ===== btc_core_bench.sv
// Purpose: self-checking bench for the buffered timer counter core
// Assumes: event counting gives exact tick control, so counts are known
// Notes:   free-running prescaled counting is only checked in frequency mode
`timescale 1ns/1ns
module btc_core_bench;
   import btc_pkg::*;
   logic           clock;
   logic           reset_n;
   btc_req_type    bus_req;
   logic [15:0]    rd_data;
   logic           event_a;
   logic [NCH-1:0] wave_out;
   logic [NCH-1:0] wave_override;
   int             fails;
   int             samples_checked;
   logic           w;

   btc_core #(.PRESCALE_W(10)) btc_core_i (
      .clock(clock), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
      .event_a(event_a), .wave_out(wave_out), .wave_override(wave_override));

   always #5 clock = ~clock;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask : wr

   // read data appear in the cycle after the strobe and hold until the next read
   task automatic rdchk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1;
      chk(rd_data & m, e);
   endtask : rdchk

   // one rising edge per count, then room for the three-stage synchroniser
   task automatic pulse(input int n);
      repeat (n) begin
         event_a <= 1'b1;
         repeat (3) @(posedge clock);
         event_a <= 1'b0;
         repeat (5) @(posedge clock);
      end
   endtask : pulse

   task automatic test_reset;
      rdchk(OFS_PERIOD, 16'hFFFF, 16'hFFFF);
      rdchk(OFS_PER_BUF, 16'hFFFF, 16'hFFFF);
      rdchk(OFS_COUNT, 16'hFFFF, 16'h0000);
      rdchk(OFS_CTRL_F, 16'hFFFF, 16'h0000);
      rdchk(5'h1F, 16'hFFFF, 16'h0000);
      $display("reset test done");
   endtask : test_reset

   task automatic test_events;
      wr(OFS_PERIOD, 16'h0002);
      wr(OFS_CMP_BASE + 5'h01, 16'h0001);
      wr(OFS_CMP_BASE + 5'h02, 16'h0004);
      rdchk(OFS_CMP_BASE + 5'h02, 16'hFFFF, 16'h0004);
      wr(OFS_EV_CTRL, 16'h0001);
      wr(OFS_CTRL_A, 16'h0001);
      wr(OFS_COUNT, 16'h0000);
      rdchk(OFS_COUNT, 16'hFFFF, 16'h0000);
      pulse(2);
      rdchk(OFS_COUNT, 16'hFFFF, 16'h0002);
      // channel 1 matched on the second tick; its flag only follows on the next tick
      rdchk(OFS_FLAGS, 16'h0002, 16'h0000);
      pulse(1);
      rdchk(OFS_COUNT, 16'hFFFF, 16'h0000);
      rdchk(OFS_FLAGS, 16'h0002, 16'h0002);
      wr(OFS_FLAGS, 16'h0002);
      rdchk(OFS_FLAGS, 16'h0002, 16'h0000);
      wr(OFS_CTRL_E, 16'h0001);
      pulse(1);
      rdchk(OFS_COUNT, 16'hFFFF, 16'h0002);
      wr(OFS_PER_BUF, 16'h0005);
      wr(OFS_CBUF_BASE + 5'h02, 16'h0009);
      rdchk(OFS_CTRL_F, 16'h0009, 16'h0009);
      rdchk(OFS_PERIOD, 16'hFFFF, 16'h0002);
      pulse(3);
      rdchk(OFS_PERIOD, 16'hFFFF, 16'h0005);
      rdchk(OFS_CMP_BASE + 5'h02, 16'hFFFF, 16'h0009);
      rdchk(OFS_CTRL_F, 16'h0009, 16'h0000);
      wr(OFS_CTRL_E, 16'h0003);
      rdchk(OFS_CTRL_E, 16'h0003, 16'h0003);
      wr(OFS_PER_BUF, 16'h0007);
      pulse(6);
      rdchk(OFS_PERIOD, 16'hFFFF, 16'h0005);
      rdchk(OFS_CTRL_F, 16'h0001, 16'h0001);
      $display("event test done");
   endtask : test_events

   task automatic test_frq;
      wr(OFS_CTRL_A, 16'h0000);
      wr(OFS_EV_CTRL, 16'h0000);
      wr(OFS_CTRL_E, 16'h0000);
      wr(OFS_COUNT, 16'h0000);
      wr(OFS_CMP_BASE, 16'h0000);
      wr(OFS_CTRL_B, 16'h0011);
      rdchk(OFS_CTRL_B, 16'h007F, 16'h0011);
      wr(OFS_CTRL_A, 16'h0001);
      repeat (6) @(posedge clock);
      #1;
      chk({13'h0000, wave_override}, 16'h0001);
      w = wave_out[0];
      @(posedge clock);
      #1;
      chk({15'h0000, wave_out[0]}, {15'h0000, ~w});
      wr(OFS_CTRL_B, 16'h0003);
      repeat (6) @(posedge clock);
      #1;
      chk({13'h0000, wave_override}, 16'h0000);
      $display("frequency test done");
   endtask : test_frq

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   initial begin
      #200000;
      fails++;
      close_out;
   end

   initial begin
      clock   = 1'b0;
      reset_n = 1'b0;
      event_a = 1'b0;
      bus_req = '{addr: 5'h00, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
      fails = 0;
      samples_checked = 0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      test_reset;
      test_events;
      test_frq;
      close_out;
   end
endmodule : btc_core_bench

// ===== btc_core_properties.sv
// Purpose: port-level properties of the buffered timer counter core
// Assumes: register map and one-cycle read timing of btc_pkg
// Notes:   shadows follow bus writes only; counter state is not modelled
`timescale 1ns/1ns
module btc_core_properties
   import btc_pkg::*;
(
   // clock and reset
   input  wire logic           clock,
   input  wire logic           reset_n,
   // observed ports
   input  wire btc_req_type    bus_req,
   input  wire logic [15:0]    rd_data,
   input  wire logic           event_a,
   input  wire logic [NCH-1:0] wave_out,
   input  wire logic [NCH-1:0] wave_override
);
   logic [15:0] ctla_q, ctlb_q, ctle_q, ev_q, compare_zero_value_q;
   logic [2:0]  quiet_q;
   logic        frq0;
   logic        pwm;

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // quiet_q gives config writes time to reach the registered outputs
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ctla_q  <= 16'h0000;
         ctlb_q  <= 16'h0000;
         ctle_q  <= 16'h0000;
         ev_q    <= 16'h0000;
         compare_zero_value_q  <= 16'h0000;
         quiet_q <= 3'h0;
      end else if (bus_req.wr) begin
         quiet_q <= 3'h0;
         if (bus_req.addr == OFS_CTRL_A) ctla_q <= bus_req.wdata;
         if (bus_req.addr == OFS_CTRL_B) ctlb_q <= bus_req.wdata;
         if (bus_req.addr == OFS_CTRL_E) ctle_q <= bus_req.wdata;
         if (bus_req.addr == OFS_EV_CTRL) ev_q <= bus_req.wdata;
         if (bus_req.addr == OFS_CMP_BASE) compare_zero_value_q <= bus_req.wdata;
      end else if (quiet_q != 3'h7) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end

   assign frq0 = ctla_q[3:0] == 4'h1 && ctlb_q[2:0] == 3'h1 && compare_zero_value_q == 16'h0000 && !ev_q[0];
   assign pwm  = ctlb_q[2:0] inside {3'h3, 3'h5, 3'h6, 3'h7};

   sequence s_read(a);
      bus_req.rd && bus_req.addr == a;
   endsequence

   a_reset_clears_out: assert property ($rose(reset_n) |-> wave_out == 3'h0 &&
      wave_override == 3'h0 && rd_data == 16'h0000) else $error("outputs not clear after reset");
   a_read_data_holds: assert property (!bus_req.rd |=> $stable(rd_data))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > 5'h0E |=> rd_data == 16'h0000)
      else $error("unmapped read not zero");
   a_mode_readback: assert property (s_read(OFS_CTRL_B) |=> rd_data[6:4] == ctlb_q[6:4] &&
      rd_data[2:0] == ctlb_q[2:0]) else $error("control b readback wrong");
   a_dir_readback: assert property (s_read(OFS_CTRL_E) |=> rd_data[1:0] == ctle_q[1:0])
      else $error("control e readback wrong");
   a_override_map: assert property (quiet_q >= 3'h2 |-> wave_override ==
      ((ctlb_q[2:0] != 3'h0) ? ctlb_q[6:4] : 3'h0)) else $error("override mismatch");
   a_frq_fast_toggle: assert property (quiet_q >= 3'h4 && frq0 |->
      wave_out[0] != $past(wave_out[0])) else $error("frequency output not toggling");
   a_pwm_wave_still: assert property (quiet_q >= 3'h2 && pwm |-> $stable(wave_out))
      else $error("waveform moved in pwm mode");
endmodule : btc_core_properties

bind btc_core btc_core_properties btc_core_properties_i (
   .clock(clock), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
   .event_a(event_a), .wave_out(wave_out), .wave_override(wave_override));

// ===== btc_pkg.sv
// Purpose: constants and types for the buffered timer counter core
// Assumes: 16-bit counter, three compare channels, plain register port
// Notes:   register offsets are word indexes on the register port
package btc_pkg;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned NCH   = 3;
   localparam int unsigned ADDR_W = 5;

   // register offsets
   localparam logic [4:0] OFS_CTRL_A    = 5'h00;
   localparam logic [4:0] OFS_CTRL_B    = 5'h01;
   localparam logic [4:0] OFS_CTRL_E    = 5'h02;
   localparam logic [4:0] OFS_CTRL_F    = 5'h03;
   localparam logic [4:0] OFS_EV_CTRL   = 5'h04;
   localparam logic [4:0] OFS_FLAGS     = 5'h05;
   localparam logic [4:0] OFS_COUNT     = 5'h06;
   localparam logic [4:0] OFS_PERIOD    = 5'h07;
   localparam logic [4:0] OFS_PER_BUF   = 5'h08;
   localparam logic [4:0] OFS_CMP_BASE  = 5'h09;
   localparam logic [4:0] OFS_CBUF_BASE = 5'h0C;

   // field positions
   localparam int unsigned BIT_ENABLE   = 0;
   localparam int unsigned POS_CLOCK_PRESCALE_SELECT   = 1;
   localparam int unsigned BIT_DIR_DOWN = 0;
   localparam int unsigned BIT_LOCK     = 1;
   localparam int unsigned BIT_EVA_EN   = 0;
   localparam int unsigned POS_CH_EN    = 4;
   localparam int unsigned BIT_PER_BV   = 0;
   localparam int unsigned POS_CMP_BV   = 1;

   // reset values
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;
   localparam logic [15:0] RST_ZERO   = 16'h0000;
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;

   typedef enum logic [2:0] {
      BTC_WG_NORMAL,
      BTC_WG_FRQ,
      BTC_WG_RSV2,
      BTC_WG_SINGLE,
      BTC_WG_RSV4,
      BTC_WG_DUAL_T,
      BTC_WG_DUAL_TB,
      BTC_WG_DUAL_B
   } btc_waveform_mode_select_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0]       wdata;
      logic              wr;
      logic              rd;
   } btc_req_type;
endpackage : btc_pkg
